// [verilog/plc_pkg.sv]
// Function
// RULE1: pullup on write clears state; off sets
// RULE2: pullup control always works; resets to zero
// RULE3: ownership take sets, release clears state
// RULE4: unmuxed lines ignore ownership writes, read one
// RULE5: ownership reset value is a product parameter
// RULE6: first choose clears, second choose sets choice
// RULE7: peripheral choice steers only outputs and enables
// RULE8: choice writes work always; choice resets zero
// RULE9: owner decides drive: peripheral or drive state
// RULE10: drive state writes work under peripheral ownership
// RULE11: level set/clear work under any ownership
// RULE12: direct level write changes only mask-enabled bits
// RULE13: direct write mask resets to zero
// RULE14: open drain set/clear; set means never high
// RULE15: open drain state resets to zero
// RULE16: pin readback shows real line level always
// RULE17: readback sampled when controller clock runs, holds
// RULE18: filter rejects under half cycle, passes one
// RULE19: filter latency one cycle or none by edge
// RULE20: deglitch on/off writes set/clear filter state
// RULE21: filter acts on readback only, needs clock
// RULE22: only bits written one change any state; a direct level write also clears mask-enabled bits written zero
package plc_pkg;
  localparam int          LINES = 32;
  localparam int          AW    = 8;
  localparam logic [7:0]  OFS_OWN_TAKE       = 8'h00;
  localparam logic [7:0]  OFS_OWN_RELEASE    = 8'h04;
  localparam logic [7:0]  OFS_OWN_STATE      = 8'h08;
  localparam logic [7:0]  OFS_DRIVE_ON       = 8'h10;
  localparam logic [7:0]  OFS_DRIVE_OFF      = 8'h14;
  localparam logic [7:0]  OFS_DRIVE_STATE    = 8'h18;
  localparam logic [7:0]  OFS_DEGLITCH_ON    = 8'h20;
  localparam logic [7:0]  OFS_DEGLITCH_OFF   = 8'h24;
  localparam logic [7:0]  OFS_DEGLITCH_STATE = 8'h28;
  localparam logic [7:0]  OFS_LEVEL_SET      = 8'h30;
  localparam logic [7:0]  OFS_LEVEL_CLEAR    = 8'h34;
  localparam logic [7:0]  OFS_DRIVEN_LEVEL   = 8'h38;
  localparam logic [7:0]  OFS_PIN_LEVEL      = 8'h3C;
  localparam logic [7:0]  OFS_OD_ON          = 8'h50;
  localparam logic [7:0]  OFS_OD_OFF         = 8'h54;
  localparam logic [7:0]  OFS_OD_STATE       = 8'h58;
  localparam logic [7:0]  OFS_PULLUP_OFF     = 8'h60;
  localparam logic [7:0]  OFS_PULLUP_ON      = 8'h64;
  localparam logic [7:0]  OFS_PULLUP_STATE   = 8'h68;
  localparam logic [7:0]  OFS_PERIPH_FIRST   = 8'h70;
  localparam logic [7:0]  OFS_PERIPH_SECOND  = 8'h74;
  localparam logic [7:0]  OFS_CHOICE_STATE   = 8'h78;
  localparam logic [7:0]  OFS_MASK_ON        = 8'hA0;
  localparam logic [7:0]  OFS_MASK_OFF       = 8'hA4;
  localparam logic [7:0]  OFS_MASK_STATE     = 8'hA8;
  localparam logic [31:0] RST_ZERO           = 32'h0000_0000;
  localparam logic [31:0] ALL_ONES           = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_OWN_DEFAULT    = 32'hFFFF_FFFF;
  localparam logic [31:0] MUXED_DEFAULT      = 32'hFFFF_FFFF;
endpackage

// [verilog/plc_wr_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface plc_wr_if;
  logic        fire;
  logic [7:0]  addr;
  logic [31:0] bits;
  modport src (output fire, output addr, output bits);
  modport dst (input fire, input addr, input bits);
endinterface
`default_nettype wire

// [verilog/plc_setclr.sv]
`timescale 1ns/1ps
`default_nettype none
module plc_setclr #(
  parameter logic [7:0]  SET_OFS = 8'h00,
  parameter logic [7:0]  CLR_OFS = 8'h04,
  parameter logic [31:0] RST     = 32'h0000_0000,
  parameter logic [31:0] FIXED   = 32'h0000_0000,
  parameter logic [31:0] FIX_VAL = 32'h0000_0000
) (
  input  wire logic  clk,
  input  wire logic  resetn,
  plc_wr_if.dst      wr,
  output logic [31:0] state
);
  // fixed bits ignore writes and always show their fixed value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= (RST & ~FIXED) | (FIX_VAL & FIXED);
    end else if (wr.fire && wr.addr == SET_OFS) begin
      state <= ((state | wr.bits) & ~FIXED) | (FIX_VAL & FIXED); // [RULE22]
    end else if (wr.fire && wr.addr == CLR_OFS) begin
      state <= (state & ~wr.bits & ~FIXED) | (FIX_VAL & FIXED); // [RULE22]
    end
  end
endmodule
`default_nettype wire

// [verilog/plc_deglitch.sv]
`timescale 1ns/1ps
`default_nettype none
module plc_deglitch (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic [31:0] pin,
  input  wire logic [31:0] filt_en,
  output logic      [31:0] level
);
  logic [31:0] half;
  // a pulse must be seen at a falling and the next rising edge to pass,
  // so anything under half a cycle can never meet both samples
  for (genvar i = 0; i < 32; i++) begin : g_line
    always_ff @(negedge clk or negedge resetn) begin
      if (!resetn) begin
        half[i] <= 1'b0;
      end else if (run) begin
        half[i] <= pin[i]; // [RULE18]
      end
    end
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        level[i] <= 1'b0;
      end else if (run) begin // [RULE17] [RULE21]
        if (!filt_en[i]) begin
          level[i] <= pin[i]; // [RULE16]
        end else if (pin[i] == half[i]) begin
          level[i] <= pin[i]; // [RULE18] [RULE19]
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verilog/plc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module plc_ctrl #(
  parameter logic [31:0] MUXED_LINES = plc_pkg::MUXED_DEFAULT,
  parameter logic [31:0] OWN_RESET   = plc_pkg::RST_OWN_DEFAULT
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic [plc_pkg::AW-1:0]  avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    ctrl_clk_en,
  input  wire logic [31:0]             pad_in,
  output logic      [31:0]             pad_out,
  output logic      [31:0]             pad_oe_n,
  output logic      [31:0]             pullup_en,
  input  wire logic [31:0]             pa_out,
  input  wire logic [31:0]             pa_oe,
  input  wire logic [31:0]             pb_out,
  input  wire logic [31:0]             pb_oe
);
  import plc_pkg::*;

  logic [31:0] byte_mask;
  logic [31:0] wr_bits;
  logic        wr_fire;
  logic [31:0] pullup_state;
  logic [31:0] line_ownership_state;
  logic [31:0] periph_choice_state;
  logic [31:0] drive_state;
  logic [31:0] driven_level_state;
  logic [31:0] direct_write_mask_state;
  logic [31:0] open_drain_state;
  logic [31:0] deglitch_state;
  logic [31:0] pin_level_readback;
  logic [31:0] next_readdata;
  logic [31:0] sel_oe;
  logic [31:0] sel_out;
  logic [31:0] drv_oe;
  logic [31:0] drv_lv;
  logic [31:0] next_oe;
  logic [31:0] next_out;

  plc_wr_if wr ();

  // byte enables gate every write, set/clear and direct alike
  assign byte_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_bits   = avs_writedata & byte_mask;
  assign wr_fire   = avs_write && !avs_waitrequest;
  assign wr.fire   = wr_fire;
  assign wr.addr   = avs_address;
  assign wr.bits   = wr_bits;

  // one wait cycle per access: waitrequest drops the cycle after the
  // request is seen and rises again as the access completes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  plc_setclr #(
    .SET_OFS (OFS_PULLUP_OFF),
    .CLR_OFS (OFS_PULLUP_ON),
    .RST     (RST_ZERO),
    .FIXED   (RST_ZERO),
    .FIX_VAL (RST_ZERO)
  ) u_pullup ( // [RULE1] [RULE2]
    .clk    (clk),
    .resetn (resetn),
    .wr     (wr.dst),
    .state  (pullup_state)
  );

  plc_setclr #(
    .SET_OFS (OFS_OWN_TAKE),
    .CLR_OFS (OFS_OWN_RELEASE),
    .RST     (OWN_RESET),
    .FIXED   (~MUXED_LINES),
    .FIX_VAL (ALL_ONES)
  ) u_own ( // [RULE3] [RULE4] [RULE5]
    .clk    (clk),
    .resetn (resetn),
    .wr     (wr.dst),
    .state  (line_ownership_state)
  );

  plc_setclr #(
    .SET_OFS (OFS_PERIPH_SECOND),
    .CLR_OFS (OFS_PERIPH_FIRST),
    .RST     (RST_ZERO),
    .FIXED   (RST_ZERO),
    .FIX_VAL (RST_ZERO)
  ) u_choice ( // [RULE6] [RULE8]
    .clk    (clk),
    .resetn (resetn),
    .wr     (wr.dst),
    .state  (periph_choice_state)
  );

  plc_setclr #(
    .SET_OFS (OFS_DRIVE_ON),
    .CLR_OFS (OFS_DRIVE_OFF),
    .RST     (RST_ZERO),
    .FIXED   (RST_ZERO),
    .FIX_VAL (RST_ZERO)
  ) u_drive ( // [RULE10]
    .clk    (clk),
    .resetn (resetn),
    .wr     (wr.dst),
    .state  (drive_state)
  );

  plc_setclr #(
    .SET_OFS (OFS_MASK_ON),
    .CLR_OFS (OFS_MASK_OFF),
    .RST     (RST_ZERO),
    .FIXED   (RST_ZERO),
    .FIX_VAL (RST_ZERO)
  ) u_mask ( // [RULE12] [RULE13]
    .clk    (clk),
    .resetn (resetn),
    .wr     (wr.dst),
    .state  (direct_write_mask_state)
  );

  plc_setclr #(
    .SET_OFS (OFS_OD_ON),
    .CLR_OFS (OFS_OD_OFF),
    .RST     (RST_ZERO),
    .FIXED   (RST_ZERO),
    .FIX_VAL (RST_ZERO)
  ) u_od ( // [RULE14] [RULE15]
    .clk    (clk),
    .resetn (resetn),
    .wr     (wr.dst),
    .state  (open_drain_state)
  );

  plc_setclr #(
    .SET_OFS (OFS_DEGLITCH_ON),
    .CLR_OFS (OFS_DEGLITCH_OFF),
    .RST     (RST_ZERO),
    .FIXED   (RST_ZERO),
    .FIX_VAL (RST_ZERO)
  ) u_deglitch ( // [RULE20]
    .clk    (clk),
    .resetn (resetn),
    .wr     (wr.dst),
    .state  (deglitch_state)
  );

  // readback only; peripherals take pad_in straight, unfiltered
  plc_deglitch u_filter ( // [RULE16] [RULE17] [RULE21]
    .clk     (clk),
    .resetn  (resetn),
    .run     (ctrl_clk_en),
    .pin     (pad_in),
    .filt_en (deglitch_state),
    .level   (pin_level_readback)
  );

  // output level: set/clear any time, direct write only through mask
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      driven_level_state <= RST_ZERO;
    end else if (wr_fire && avs_address == OFS_LEVEL_SET) begin
      driven_level_state <= driven_level_state | wr_bits; // [RULE11]
    end else if (wr_fire && avs_address == OFS_LEVEL_CLEAR) begin
      driven_level_state <= driven_level_state & ~wr_bits; // [RULE11]
    end else if (wr_fire && avs_address == OFS_DRIVEN_LEVEL) begin
      driven_level_state <=
        (driven_level_state & ~(direct_write_mask_state & byte_mask)) |
        (avs_writedata & direct_write_mask_state & byte_mask); // [RULE12]
    end
  end

  // choice steers outputs and enables only; inputs are never muxed
  assign sel_oe  = (periph_choice_state & pb_oe) |
                   (~periph_choice_state & pa_oe); // [RULE7]
  assign sel_out = (periph_choice_state & pb_out) |
                   (~periph_choice_state & pa_out); // [RULE7]
  assign drv_oe  = (line_ownership_state & drive_state) |
                   (~line_ownership_state & sel_oe); // [RULE9]
  assign drv_lv  = (line_ownership_state & driven_level_state) |
                   (~line_ownership_state & sel_out); // [RULE9]
  // open drain drives only a low; a high releases the pad
  assign next_oe  = drv_oe & ~(open_drain_state & drv_lv); // [RULE14]
  assign next_out = drv_lv & ~open_drain_state; // [RULE14]

  // pads are registered, so every pin change lags its cause by one cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pad_oe_n  <= ALL_ONES;
      pad_out   <= RST_ZERO;
      pullup_en <= ALL_ONES;
    end else begin
      pad_oe_n  <= ~next_oe;
      pad_out   <= next_out;
      pullup_en <= ~pullup_state; // [RULE1]
    end
  end

  always_comb begin
    next_readdata = RST_ZERO;
    case (avs_address)
      OFS_OWN_STATE:      next_readdata = line_ownership_state;
      OFS_DRIVE_STATE:    next_readdata = drive_state;
      OFS_DEGLITCH_STATE: next_readdata = deglitch_state;
      OFS_DRIVEN_LEVEL:   next_readdata = driven_level_state;
      OFS_PIN_LEVEL:      next_readdata = pin_level_readback; // [RULE16]
      OFS_OD_STATE:       next_readdata = open_drain_state;
      OFS_PULLUP_STATE:   next_readdata = pullup_state;
      OFS_CHOICE_STATE:   next_readdata = periph_choice_state;
      OFS_MASK_STATE:     next_readdata = direct_write_mask_state;
      default:            next_readdata = RST_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= RST_ZERO;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  AST_PULLUP_ON_CLEARS: assert property ( // [RULE1]
    wr_fire && avs_address == OFS_PULLUP_ON
    |=> (pullup_state & $past(wr_bits)) == RST_ZERO ##1
        (pullup_en & $past(wr_bits, 2)) == $past(wr_bits, 2))
    else $error("pullup on write did not enable pullup");

  AST_PULLUP_OFF_SETS: assert property ( // [RULE2]
    wr_fire && avs_address == OFS_PULLUP_OFF
    |=> (pullup_state & $past(wr_bits)) == $past(wr_bits))
    else $error("pullup off write did not set state");

  AST_UNMUXED_OWNED: assert property ( // [RULE4]
    (~MUXED_LINES & ~line_ownership_state) == RST_ZERO)
    else $error("unmuxed line lost controller ownership");

  AST_OWN_RELEASE: assert property ( // [RULE3]
    wr_fire && avs_address == OFS_OWN_RELEASE
    |=> (line_ownership_state & $past(wr_bits) & MUXED_LINES)
        == RST_ZERO)
    else $error("ownership release ignored");

  AST_CHOICE_SECOND: assert property ( // [RULE6]
    wr_fire && avs_address == OFS_PERIPH_SECOND
    |=> (periph_choice_state & $past(wr_bits)) == $past(wr_bits))
    else $error("second peripheral choice not set");

  AST_OWNED_DRIVE: assert property ( // [RULE9]
    1'b1 |=> (pad_oe_n ^ ~$past(next_oe)) == RST_ZERO &&
             ($past(line_ownership_state & drive_state &
                    ~open_drain_state) & pad_oe_n) == RST_ZERO)
    else $error("owned line with drive state not driven");

  AST_OD_NEVER_HIGH: assert property ( // [RULE14]
    1'b1 |=> (~pad_oe_n & pad_out & $past(open_drain_state)) == RST_ZERO)
    else $error("open drain pad driven high");

  AST_MASKED_DIRECT: assert property ( // [RULE12]
    wr_fire && avs_address == OFS_DRIVEN_LEVEL
    |=> ((driven_level_state ^ $past(driven_level_state)) &
         ~$past(direct_write_mask_state)) == RST_ZERO)
    else $error("direct write changed a masked bit");

  AST_READBACK_HOLD: assert property ( // [RULE17]
    !ctrl_clk_en |=> $stable(pin_level_readback))
    else $error("readback moved while controller clock stopped");

  AST_UNFILTERED_PATH: assert property ( // [RULE16]
    ctrl_clk_en && deglitch_state == RST_ZERO
    |=> pin_level_readback == $past(pad_in))
    else $error("readback does not follow pad level");

  AST_ONE_WAIT: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest
    ##1 avs_waitrequest)
    else $error("access not answered after one wait cycle");

  AST_CHOICE_FIRST: assert property ( // [RULE6]
    wr_fire && avs_address == OFS_PERIPH_FIRST
    |=> (periph_choice_state & $past(wr_bits)) == RST_ZERO)
    else $error("first peripheral choice not cleared");

  AST_DRIVE_ON_SETS: assert property ( // [RULE10]
    wr_fire && avs_address == OFS_DRIVE_ON
    |=> (drive_state & $past(wr_bits)) == $past(wr_bits))
    else $error("drive on write did not set drive state");

  AST_DRIVE_UNTOUCHED: assert property ( // [RULE22]
    wr_fire && (avs_address == OFS_DRIVE_ON ||
                avs_address == OFS_DRIVE_OFF)
    |=> ((drive_state ^ $past(drive_state)) & ~$past(wr_bits))
        == RST_ZERO)
    else $error("drive write changed a bit written as zero");

  AST_LEVEL_CLEAR: assert property ( // [RULE11]
    wr_fire && avs_address == OFS_LEVEL_CLEAR
    |=> (driven_level_state & $past(wr_bits)) == RST_ZERO)
    else $error("level clear write did not clear level");

  AST_MASK_ON_SETS: assert property ( // [RULE12]
    wr_fire && avs_address == OFS_MASK_ON
    |=> (direct_write_mask_state & $past(wr_bits)) == $past(wr_bits))
    else $error("mask on write did not set mask state");

  AST_OD_OFF_CLEARS: assert property ( // [RULE14]
    wr_fire && avs_address == OFS_OD_OFF
    |=> (open_drain_state & $past(wr_bits)) == RST_ZERO)
    else $error("open drain off write did not clear state");

  AST_DEGLITCH_ON_SETS: assert property ( // [RULE20]
    wr_fire && avs_address == OFS_DEGLITCH_ON
    |=> (deglitch_state & $past(wr_bits)) == $past(wr_bits))
    else $error("deglitch on write did not set filter state");

  AST_PERIPH_DRIVE: assert property ( // [RULE9]
    1'b1 |=> ($past(~line_ownership_state & ~open_drain_state & sel_oe)
              & pad_oe_n) == RST_ZERO)
    else $error("peripheral drive request not driven on pad");

  COV_HANDOVER: cover property (
    wr_fire && avs_address == OFS_OWN_RELEASE ##[1:20]
    !pad_oe_n[16] && !line_ownership_state[16]);
  COV_DIRECT_WRITE: cover property (
    wr_fire && avs_address == OFS_DRIVEN_LEVEL &&
    direct_write_mask_state != RST_ZERO);
  COV_FILTERED_READ: cover property (
    deglitch_state[8] && $changed(pin_level_readback[8]));
  COV_OPEN_DRAIN_LOW: cover property (open_drain_state[0] && !pad_oe_n[0]);
endmodule
`default_nettype wire

// [verif/plc_pad_model.sv]
`timescale 1ns/1ps
`default_nettype none
module plc_pad_model (
  input  wire logic        clk,
  input  wire logic [31:0] pad_out,
  input  wire logic [31:0] pad_oe_n,
  input  wire logic [31:0] pullup_en,
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_lvl,
  output logic      [31:0] pad_in
);
  // a line nobody holds wanders each cycle so a stale level never passes
  logic [31:0] drift = 32'h0000_0000;

  always_ff @(posedge clk) begin
    drift <= ~drift;
  end

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!pad_oe_n[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_lvl[i];
      else if (pullup_en[i])
        pad_in[i] = 1'b1;
      else
        pad_in[i] = drift[i];
    end
  end
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import plc_pkg::*;
  localparam logic [31:0] MUXED = 32'h7FFF_FFFF;
  localparam logic [31:0] OWN_R = 32'hFFFF_FF0F;
  localparam logic [31:0] PMASK = 32'h0FC3_FFFF;
  localparam logic [7:0]  ZR [8] = '{OFS_DRIVE_STATE, OFS_DEGLITCH_STATE,
    OFS_DRIVEN_LEVEL, OFS_OD_STATE, OFS_PULLUP_STATE, OFS_CHOICE_STATE,
    OFS_MASK_STATE, 8'h0C};
  logic        clk, resetn, avs_read, avs_write, avs_waitrequest, ctrl_clk_en;
  logic [7:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, pad_in, pad_out, pad_oe_n;
  logic [31:0] pullup_en, pa_out, pa_oe, pb_out, pb_oe, ext_en, ext_lvl;
  logic [31:0] rd_val;
  int          mismatches, checks;

  plc_ctrl #(.MUXED_LINES(MUXED), .OWN_RESET(OWN_R)) u_plc_ctrl (
    .clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ctrl_clk_en(ctrl_clk_en), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pullup_en(pullup_en), .pa_out(pa_out),
    .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe));

  plc_pad_model u_plc_pad_model (
    .clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pullup_en(pullup_en), .ext_en(ext_en), .ext_lvl(ext_lvl),
    .pad_in(pad_in));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop;
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // the request stands until waitrequest is seen low at a rising edge;
  // only the watchdog ends a wait that never gets its answer
  task automatic bus(input logic rd, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_read      <= rd;
    avs_write     <= !rd;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd_val = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    bus(1'b1, a, 32'h0000_0000);
    chk(rd_val & m, e);
  endtask

  // pulse on line 8, then the clock enable drops so readback freezes
  task automatic pulse(input logic full, input logic e);
    @(posedge clk);
    #0.5;
    if (full)
      ext_lvl[8] = 1'b1;
    @(negedge clk);
    #1.5;
    ext_lvl[8] = 1'b1;
    @(posedge clk);
    ctrl_clk_en <= 1'b0;
    #0.5;
    ext_lvl[8] = 1'b0;
    rdc(OFS_PIN_LEVEL, 32'h0000_0100, {23'h0, e, 8'h00});
    ctrl_clk_en <= 1'b1;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end

  initial begin
    resetn = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    ctrl_clk_en = 1'b1;
    pa_out = 32'hAAAA_AAAA;
    pa_oe = 32'h0003_0000;
    pb_out = 32'h5555_5555;
    pb_oe = 32'h00C0_0000;
    ext_en = 32'h0000_0F00;
    ext_lvl = 32'h0000_0500;
    mismatches = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rdc(OFS_OWN_STATE, ALL_ONES, OWN_R | ~MUXED);
    for (int i = 0; i < 8; i++)
      rdc(ZR[i], ALL_ONES, RST_ZERO);
    chk(pullup_en, ALL_ONES);
    wr(OFS_OWN_RELEASE, ALL_ONES);
    rdc(OFS_OWN_STATE, ALL_ONES, 32'h8000_0000);
    wr(OFS_OWN_TAKE, 32'h0000_0FFF);
    wr(OFS_OWN_RELEASE, 32'h8000_0000);
    wr(OFS_OWN_STATE, RST_ZERO);
    rdc(OFS_OWN_STATE, ALL_ONES, 32'h8000_0FFF);
    wr(OFS_PERIPH_SECOND, 32'h00FF_0000);
    wr(OFS_PERIPH_FIRST, 32'h000F_0000);
    rdc(OFS_CHOICE_STATE, ALL_ONES, 32'h00F0_0000);
    wr(OFS_DRIVE_ON, 32'h00FF_000F);
    wr(OFS_DRIVE_OFF, 32'h00F0_0000);
    rdc(OFS_DRIVE_STATE, ALL_ONES, 32'h000F_000F);
    wr(OFS_LEVEL_SET, 32'h000F_000F);
    wr(OFS_LEVEL_CLEAR, 32'h000A_0000);
    rdc(OFS_DRIVEN_LEVEL, ALL_ONES, 32'h0005_000F);
    wr(OFS_MASK_ON, 32'h0000_00FF);
    wr(OFS_MASK_OFF, 32'h0000_00F0);
    rdc(OFS_MASK_STATE, ALL_ONES, 32'h0000_000F);
    wr(OFS_DRIVEN_LEVEL, 32'hFFFF_FFF5);
    rdc(OFS_DRIVEN_LEVEL, ALL_ONES, 32'h0005_0005);
    wr(OFS_OD_ON, 32'h0000_0003);
    wr(OFS_OD_OFF, 32'h0000_0002);
    rdc(OFS_OD_STATE, ALL_ONES, 32'h0000_0001);
    wr(OFS_PULLUP_OFF, 32'hFFFF_0000);
    wr(OFS_PULLUP_ON, 32'h0F00_0000);
    rdc(OFS_PULLUP_STATE, ALL_ONES, 32'hF0FF_0000);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(pullup_en, 32'h0F00_FFFF);
    chk(pad_oe_n, 32'hFF3C_FFF1);
    chk(pad_out & 32'h00C3_000E, 32'h0042_0004);
    rdc(OFS_PIN_LEVEL, PMASK, 32'h0F42_F5F5);
    ctrl_clk_en <= 1'b0;
    ext_lvl <= 32'h0000_0A00;
    rdc(OFS_PIN_LEVEL, PMASK, 32'h0F42_F5F5);
    ctrl_clk_en <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(OFS_PIN_LEVEL, PMASK, 32'h0F42_FAF5);
    pulse(1'b0, 1'b1);
    wr(OFS_DEGLITCH_ON, 32'h0000_0300);
    wr(OFS_DEGLITCH_OFF, 32'h0000_0200);
    rdc(OFS_DEGLITCH_STATE, ALL_ONES, 32'h0000_0100);
    pulse(1'b0, 1'b0);
    pulse(1'b1, 1'b1);
    // only the second byte lane may reach the open drain state
    avs_byteenable <= 4'h2;
    wr(OFS_OD_ON, ALL_ONES);
    avs_byteenable <= 4'hF;
    rdc(OFS_OD_STATE, ALL_ONES, 32'h0000_FF01);
    wr(OFS_LEVEL_CLEAR, 32'h0000_0001);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(pad_oe_n & 32'h0000_0001, RST_ZERO);
    chk(pad_out & 32'h0000_0001, RST_ZERO);
    report_and_stop;
  end
endmodule
`default_nettype wire
